// file: rtl/tda_engine.sv
// display list walker, attribute decoder and character output stage
//
// What this block does
// - walk window blocks topmost first, by link
// - window row blocks handled like background rows
// - scroll per line, pulse when row done
// - scroll rate is a programmable frame count
// - fetch attribute only after flagged character
// - unlatched hits next char, latched persists
// - flag is dedicated code or code msb
// - ten predefined, four user bits, reassignable
// - highlight and reverse go to serializer
// - superscript up, subscript down by lines
// - underline at programmed line, strike shifted
// - blink with programmable rate and duty
// - script shifting can be switched off
// - ignore bit drops character from buffer
// - latched bit stores word, never user bit
// - system clock times fetches and counters
// - one xy cursor fixed on screen
// - attribute cursor travels with its character
// - separate styles for both cursor kinds
// - program first, then fetch, then display
// - linear 24-bit or segmented 23-bit addresses
// - window walk starts at top-of-window pointer
`timescale 1ns/1ps
module tda_engine #(
	parameter int DEPTH = tda_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ctrl_enable,
	input wire logic [23:0] top_of_page_ptr,
	input wire logic [23:0] top_of_window_ptr,
	input wire logic seg_mode,
	input wire logic demand_mode,
	input wire logic flag_is_msb,
	input wire logic [7:0] flag_code,
	input wire logic [9:0] redef_mask,
	input wire logic script_bypass,
	input wire logic [4:0] script_shift,
	input wire logic [4:0] ul_pos,
	input wire logic [4:0] strike_ofs,
	input wire logic [7:0] blink_period,
	input wire logic [7:0] blink_on_frames,
	input wire logic [2:0] xy_style,
	input wire logic [2:0] attr_style,
	input wire logic scroll_enable,
	input wire logic [7:0] scroll_rate,
	input wire logic [4:0] row_lines,
	input wire logic frame_start,
	input wire logic char_tick,
	input wire logic [4:0] scan_line,
	input wire logic bus_grant_pin,
	output logic bus_req_r,
	output logic rd_req_r,
	output logic [23:0] mem_addr_r,
	input wire logic rd_ack,
	input wire logic [15:0] mem_rdata,
	output logic disp_active_r,
	output logic [7:0] char_code_r,
	output logic [4:0] row_addr_r,
	output logic [13:0] attr_pins_r,
	output logic highlight_r,
	output logic reverse_r,
	output logic line_on_r,
	output logic blank_r,
	output logic scroll_row_done_r,
	output logic [4:0] scroll_off_r
);
	// ----------------------------------------------------------------
	// bus grant synchroniser
	// ----------------------------------------------------------------
	logic [2:0] gnt_sync_r;
	logic gnt_r;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gnt_sync_r <= 3'h0;
			gnt_r <= 1'b0;
		end else if (clk_en) begin
			gnt_sync_r <= {gnt_sync_r[1:0], bus_grant_pin};
			if (gnt_sync_r[1] == gnt_sync_r[2]) begin
				gnt_r <= gnt_sync_r[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// list walker
	// ----------------------------------------------------------------
	tda_pkg::tda_state_type state_r;
	logic [23:0] ptr_r;
	logic [2:0] idx_r;
	logic [15:0] tmp_lo_r;
	logic [23:0] next_rcb_r;
	logic [23:0] str_ptr_r;
	logic [23:0] wdb_next_r;
	logic in_window_r;
	logic [7:0] cnt_r;
	logic [7:0] cur_x_r;
	logic [7:0] cur_y_r;
	logic [7:0] held_char_r;
	logic [15:0] latched_r;
	logic [15:0] oneshot_r;
	logic oneshot_v_r;
	logic list_done_r;

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [24:0] fifo_out_data;

	// system clock drives every fetch and counter here
	wire logic ack = rd_ack && rd_req_r;
	wire logic [23:0] rd_addr = ptr_r + {20'h00000, idx_r, 1'b0};
	wire logic [23:0] word_ptr = {mem_rdata[7:0], tmp_lo_r};
	wire logic [23:0] ptr_step = ptr_r + 24'h000002;
	// flag is either a reserved code or the top code bit
	wire logic is_flag = demand_mode && (flag_is_msb ? mem_rdata[7]
		: mem_rdata[7:0] == flag_code);
	wire logic [15:0] attr_use = oneshot_v_r ? oneshot_r : latched_r;
	wire logic drop = attr_use[tda_pkg::A_IGNORE];
	wire logic push_chr = state_r == tda_pkg::ST_PUSH && !drop;
	wire logic push_eor = state_r == tda_pkg::ST_ROWEND;
	wire logic fifo_push = (push_chr || push_eor) && fifo_in_ready;
	wire logic [24:0] fifo_in_data = {push_eor, held_char_r, attr_use};
	wire logic reading = state_r inside {tda_pkg::ST_MDB, tda_pkg::ST_WDB,
		tda_pkg::ST_RCB, tda_pkg::ST_CHR, tda_pkg::ST_ATR};
	// chain end: next row, else next window, else list finished
	wire logic more_rows = next_rcb_r != tda_pkg::PTR_NULL;
	wire logic first_win = !in_window_r
		&& top_of_window_ptr != tda_pkg::PTR_NULL;
	wire logic more_win = in_window_r && wdb_next_r != tda_pkg::PTR_NULL;
	wire logic [23:0] win_ptr = in_window_r ? wdb_next_r : top_of_window_ptr;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= tda_pkg::ST_IDLE;
			bus_req_r <= 1'b0;
			rd_req_r <= 1'b0;
			mem_addr_r <= 24'h000000;
			ptr_r <= 24'h000000;
			idx_r <= 3'h0;
			tmp_lo_r <= 16'h0000;
			next_rcb_r <= 24'h000000;
			str_ptr_r <= 24'h000000;
			wdb_next_r <= 24'h000000;
			in_window_r <= 1'b0;
			cnt_r <= 8'h00;
			cur_x_r <= 8'h00;
			cur_y_r <= 8'h00;
			held_char_r <= 8'h00;
			latched_r <= tda_pkg::ATTR_RST;
			oneshot_r <= tda_pkg::ATTR_RST;
			oneshot_v_r <= 1'b0;
			list_done_r <= 1'b0;
		end else if (clk_en) begin
			if (reading && !rd_req_r && !ack) begin
				rd_req_r <= 1'b1;
				// segmented space keeps bit 23 clear
				mem_addr_r <= seg_mode ? {1'b0, rd_addr[22:0]} : rd_addr;
			end else if (ack) begin
				rd_req_r <= 1'b0;
			end
			if (!ctrl_enable) begin
				state_r <= tda_pkg::ST_IDLE;
				bus_req_r <= 1'b0;
				rd_req_r <= 1'b0;
			end else if (frame_start && state_r != tda_pkg::ST_IDLE) begin
				// previous frame work is abandoned at frame start
				state_r <= tda_pkg::ST_BUSREQ;
				bus_req_r <= 1'b1;
				rd_req_r <= 1'b0;
				latched_r <= tda_pkg::ATTR_RST;
				oneshot_v_r <= 1'b0;
				list_done_r <= 1'b0;
			end else begin
				case (state_r)
				tda_pkg::ST_IDLE: begin
					// only once enabled does the block seek the bus
					state_r <= tda_pkg::ST_BUSREQ;
					bus_req_r <= 1'b1;
				end
				tda_pkg::ST_BUSREQ: begin
					if (gnt_r) begin
						state_r <= tda_pkg::ST_MDB;
						ptr_r <= top_of_page_ptr;
						idx_r <= 3'h0;
						in_window_r <= 1'b0;
					end
				end
				tda_pkg::ST_MDB: begin
					if (ack) begin
						tmp_lo_r <= mem_rdata;
						idx_r <= idx_r + 3'h1;
						if (idx_r == 3'h1) begin
							next_rcb_r <= word_ptr;
						end
						if (idx_r == tda_pkg::MDB_LAST) begin
							// single coordinate pair for the xy cursor
							cur_x_r <= mem_rdata[7:0];
							cur_y_r <= mem_rdata[15:8];
							state_r <= tda_pkg::ST_RCB;
							ptr_r <= next_rcb_r;
							idx_r <= 3'h0;
						end
					end
				end
				tda_pkg::ST_WDB: begin
					if (ack) begin
						tmp_lo_r <= mem_rdata;
						idx_r <= idx_r + 3'h1;
						if (idx_r == 3'h1) begin
							wdb_next_r <= word_ptr;
						end
						if (idx_r == tda_pkg::WDB_LAST) begin
							// window rows reuse the background row path
							state_r <= tda_pkg::ST_RCB;
							ptr_r <= word_ptr;
							idx_r <= 3'h0;
							in_window_r <= 1'b1;
						end
					end
				end
				tda_pkg::ST_RCB: begin
					if (ack) begin
						tmp_lo_r <= mem_rdata;
						idx_r <= idx_r + 3'h1;
						if (idx_r == 3'h1) begin
							next_rcb_r <= word_ptr;
						end
						// string pointer parked: the count word still
						// has to be read relative to the row block
						if (idx_r == 3'h3) begin
							str_ptr_r <= word_ptr;
						end
						if (idx_r == tda_pkg::RCB_LAST) begin
							ptr_r <= str_ptr_r;
							cnt_r <= mem_rdata[7:0];
							idx_r <= 3'h0;
							state_r <= (mem_rdata[7:0] == 8'h00)
								? tda_pkg::ST_ROWEND : tda_pkg::ST_CHR;
						end
					end
				end
				tda_pkg::ST_CHR: begin
					if (ack) begin
						ptr_r <= ptr_step;
						cnt_r <= cnt_r - 8'h01;
						held_char_r <= flag_is_msb ? {1'b0, mem_rdata[6:0]}
							: mem_rdata[7:0];
						// plain characters never trigger a fetch
						if (is_flag) begin
							state_r <= tda_pkg::ST_ATR;
						end else begin
							state_r <= tda_pkg::ST_PUSH;
						end
					end
				end
				tda_pkg::ST_ATR: begin
					if (ack) begin
						ptr_r <= ptr_step;
						if (mem_rdata[tda_pkg::A_LATCHED]) begin
							latched_r <= mem_rdata;
						end else begin
							oneshot_r <= mem_rdata;
							oneshot_v_r <= 1'b1;
						end
						if (flag_is_msb) begin
							state_r <= tda_pkg::ST_PUSH;
						end else if (cnt_r == 8'h00) begin
							state_r <= tda_pkg::ST_ROWEND;
						end else begin
							state_r <= tda_pkg::ST_CHR;
						end
					end
				end
				tda_pkg::ST_PUSH: begin
					// ignored characters consume the slot but never load
					if (drop || fifo_in_ready) begin
						oneshot_v_r <= 1'b0;
						state_r <= (cnt_r == 8'h00) ? tda_pkg::ST_ROWEND
							: tda_pkg::ST_CHR;
					end
				end
				tda_pkg::ST_ROWEND: begin
					if (fifo_in_ready) begin
						idx_r <= 3'h0;
						if (more_rows) begin
							state_r <= tda_pkg::ST_RCB;
							ptr_r <= next_rcb_r;
						end else if (first_win || more_win) begin
							// first window from top-of-window pointer, later ones by link
							state_r <= tda_pkg::ST_WDB;
							ptr_r <= win_ptr;
						end else begin
							state_r <= tda_pkg::ST_DONE;
							bus_req_r <= 1'b0;
							list_done_r <= 1'b1;
						end
					end
				end
				default: begin
					state_r <= state_r;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// character buffer
	// ----------------------------------------------------------------
	// fetch stalls in push states when full, so the display paces list reads
	wire logic pop = disp_active_r && char_tick && fifo_out_valid;
	tda_fifo #(
		.WIDTH(tda_pkg::ENTRY_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// screen counters: blink, scroll, cursor position
	// ----------------------------------------------------------------
	logic [7:0] blink_cnt_r;
	logic [7:0] scroll_cnt_r;
	logic [7:0] col_r;
	logic [7:0] row_r;
	wire logic blink_on = blink_cnt_r < blink_on_frames;
	wire logic scroll_step = scroll_enable && scroll_cnt_r == scroll_rate;
	wire logic scroll_wrap = scroll_off_r == row_lines - 5'h01;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			blink_cnt_r <= 8'h00;
			scroll_cnt_r <= 8'h00;
			scroll_off_r <= 5'h00;
			scroll_row_done_r <= 1'b0;
		end else if (clk_en) begin
			scroll_row_done_r <= 1'b0;
			if (frame_start) begin
				// rate and duty counted in frames
				blink_cnt_r <= (blink_cnt_r >= blink_period) ? 8'h00
					: blink_cnt_r + 8'h01;
				// step one line every scroll_rate+1 frames
				scroll_cnt_r <= scroll_step ? 8'h00 : scroll_cnt_r + 8'h01;
				if (!scroll_enable) begin
					scroll_cnt_r <= 8'h00;
				end
				if (scroll_step) begin
					scroll_off_r <= scroll_wrap ? 5'h00 : scroll_off_r + 5'h01;
					scroll_row_done_r <= scroll_wrap;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// attribute processing and outputs
	// ----------------------------------------------------------------
	function automatic logic [2:0] cursor_fx(input logic [2:0] sty,
			input logic bon);
		logic [2:0] fx;
		fx = 3'h0;
		case (sty)
		tda_pkg::STY_UL: fx = 3'h4;
		tda_pkg::STY_UL_BLINK: fx = {bon, 2'h0};
		tda_pkg::STY_BLANK_BLINK: fx = {2'h0, !bon};
		tda_pkg::STY_REV_BLINK: fx = {1'b0, bon, 1'b0};
		tda_pkg::STY_REV: fx = 3'h2;
		default: fx = 3'h0;
		endcase
		return fx;
	endfunction : cursor_fx

	wire logic [15:0] a_raw = fifo_out_data[15:0];
	// reassigned predefined bits lose their internal effect
	wire logic [9:0] a_eff = a_raw[9:0] & ~redef_mask;
	wire logic eor = fifo_out_data[tda_pkg::E_EOR];
	wire logic xy_hit = col_r == cur_x_r && row_r == cur_y_r;
	wire logic [2:0] xy_fx = xy_hit ? cursor_fx(xy_style, blink_on) : 3'h0;
	wire logic [2:0] at_fx = a_eff[tda_pkg::A_CURSOR]
		? cursor_fx(attr_style, blink_on) : 3'h0;
	wire logic at_ul_line = scan_line == ul_pos;
	wire logic at_st_line = scan_line == ul_pos - strike_ofs;
	wire logic line_on = (a_eff[tda_pkg::A_UNDER] && at_ul_line)
		|| (a_eff[tda_pkg::A_STRIKE] && at_st_line)
		|| ((xy_fx[2] || at_fx[2]) && at_ul_line);
	wire logic [4:0] base_line = scan_line + scroll_off_r;
	wire logic [4:0] row_addr = script_bypass ? base_line
		: a_eff[tda_pkg::A_SUPER] ? base_line + script_shift
		: a_eff[tda_pkg::A_SUB] ? base_line - script_shift
		: base_line;
	wire logic blank = (a_eff[tda_pkg::A_BLINK] && !blink_on)
		|| xy_fx[0] || at_fx[0];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			disp_active_r <= 1'b0;
			col_r <= 8'h00;
			row_r <= 8'h00;
			char_code_r <= 8'h00;
			row_addr_r <= 5'h00;
			attr_pins_r <= 14'h0000;
			highlight_r <= 1'b0;
			reverse_r <= 1'b0;
			line_on_r <= 1'b0;
			blank_r <= 1'b1;
		end else if (clk_en) begin
			// display once the buffer has filled or the list is finished
			if (!ctrl_enable) begin
				disp_active_r <= 1'b0;
			end else if (!fifo_in_ready || list_done_r) begin
				disp_active_r <= 1'b1;
			end
			if (frame_start) begin
				col_r <= 8'h00;
				row_r <= 8'h00;
			end else if (pop && eor) begin
				col_r <= 8'h00;
				row_r <= row_r + 8'h01;
			end else if (pop) begin
				col_r <= col_r + 8'h01;
			end
			if (char_tick) begin
				char_code_r <= fifo_out_data[23:16];
				row_addr_r <= row_addr;
				attr_pins_r <= a_raw[13:0];
				highlight_r <= pop && !eor && a_eff[tda_pkg::A_HIGHLIGHT];
				reverse_r <= pop && !eor
					&& (a_eff[tda_pkg::A_REVERSE] ^ (xy_fx[1] || at_fx[1]));
				line_on_r <= pop && !eor && line_on;
				blank_r <= !pop || eor || blank;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_READ_NEEDS_BUS: assert property (@(posedge ref_clk) disable iff (rst)
		rd_req_r |-> bus_req_r) else $error("read issued without bus request");
	AST_SEG_TOP_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
		seg_mode && $rose(rd_req_r) |-> !mem_addr_r[23])
		else $error("segmented address used bit 23");
	AST_IGNORE_NO_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == tda_pkg::ST_PUSH && drop |-> !fifo_push)
		else $error("ignored character entered the buffer");
	AST_LATCH_CLEARED: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ctrl_enable && frame_start && state_r != tda_pkg::ST_IDLE
		|=> latched_r == tda_pkg::ATTR_RST)
		else $error("latched attribute survived frame start");
	AST_ONESHOT_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ctrl_enable && !frame_start && fifo_push && push_chr
		|=> !oneshot_v_r) else $error("unlatched attribute reused");
	AST_NO_DEMAND_FETCH: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ctrl_enable && !frame_start && state_r == tda_pkg::ST_CHR
		&& ack && !is_flag |=> state_r == tda_pkg::ST_PUSH)
		else $error("attribute fetched for unflagged character");
	AST_WDB_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
		$past(clk_en) && state_r == tda_pkg::ST_WDB
		&& $past(state_r) == tda_pkg::ST_ROWEND
		|-> ptr_r == ($past(in_window_r) ? $past(wdb_next_r)
		: $past(top_of_window_ptr)))
		else $error("window block taken out of order");
	AST_WIN_ROWS: assert property (@(posedge ref_clk) disable iff (rst)
		$past(clk_en) && state_r == tda_pkg::ST_RCB
		&& $past(state_r) == tda_pkg::ST_WDB
		|-> ptr_r == {$past(mem_rdata[7:0]), $past(tmp_lo_r)} && in_window_r)
		else $error("window row pointer not followed");
	AST_SCROLL_DONE: assert property (@(posedge ref_clk) disable iff (rst)
		$past(clk_en) && scroll_row_done_r |-> scroll_off_r == 5'h00
		&& $past(scroll_off_r) == row_lines - 5'h01)
		else $error("scroll pulse before full row");
	COV_LIST_DONE: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(list_done_r));
	COV_WINDOW: cover property (@(posedge ref_clk) disable iff (rst)
		state_r == tda_pkg::ST_WDB ##[1:200] state_r == tda_pkg::ST_RCB);
	COV_SCROLL: cover property (@(posedge ref_clk) disable iff (rst)
		scroll_row_done_r);
	COV_LATCH: cover property (@(posedge ref_clk) disable iff (rst)
		ack && state_r == tda_pkg::ST_ATR && mem_rdata[tda_pkg::A_LATCHED]);

endmodule : tda_engine

// file: rtl/tda_pkg.sv
// shared constants and types of the text display list and attribute engine
package tda_pkg;

	// ----------------------------------------------------------------
	// bus and list geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	// last word index of each control block
	localparam logic [2:0] MDB_LAST = 3'h2;
	localparam logic [2:0] WDB_LAST = 3'h3;
	localparam logic [2:0] RCB_LAST = 3'h4;
	localparam logic [23:0] PTR_NULL = 24'h000000;

	// ----------------------------------------------------------------
	// attribute word layout
	// ----------------------------------------------------------------
	localparam int NUM_PREDEF = 10;
	localparam int NUM_USER = 4;
	localparam int A_HIGHLIGHT = 0;
	localparam int A_REVERSE = 1;
	localparam int A_SUPER = 2;
	localparam int A_SUB = 3;
	localparam int A_UNDER = 4;
	localparam int A_STRIKE = 5;
	localparam int A_BLINK = 6;
	localparam int A_CURSOR = 7;
	localparam int A_IGNORE = 14;
	localparam int A_LATCHED = 15;
	localparam logic [15:0] ATTR_RST = 16'h0000;

	// ----------------------------------------------------------------
	// fifo entry: end-of-row flag, character code, attribute word
	// ----------------------------------------------------------------
	localparam int ENTRY_W = 25;
	localparam int E_EOR = 24;

	// ----------------------------------------------------------------
	// cursor styles
	// ----------------------------------------------------------------
	localparam logic [2:0] STY_UL = 3'h0;
	localparam logic [2:0] STY_UL_BLINK = 3'h1;
	localparam logic [2:0] STY_BLANK_BLINK = 3'h2;
	localparam logic [2:0] STY_REV_BLINK = 3'h3;
	localparam logic [2:0] STY_REV = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE, ST_BUSREQ, ST_MDB, ST_WDB, ST_RCB,
		ST_CHR, ST_ATR, ST_PUSH, ST_ROWEND, ST_DONE
	} tda_state_type;

endpackage : tda_pkg

// file: rtl/tda_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module tda_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	wire logic do_wr = in_valid && in_ready && clk_en;
	wire logic do_rd = out_valid && out_ready && clk_en;

	assign in_ready = count_r != FULL_CNT;
	assign out_valid = count_r != '0;
	assign out_data = mem[rd_ptr_r];

	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_r <= count_r + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule : tda_fifo

// file: test/tda_mem_model.sv
// host memory and bus arbiter model facing the engine's master port
`timescale 1ns/1ps
module tda_mem_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic bus_req_r,
	input wire logic rd_req_r,
	input wire logic [23:0] mem_addr_r,
	output logic bus_grant_pin,
	output logic rd_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:2047];
	int gcnt;
	int wcnt;
	// ----------------------------------------------------------------
	// grant and read answers
	// ----------------------------------------------------------------
	// grant comes late so the engine must wait before fetching
	always @(posedge ref_clk) begin
		rd_ack <= 1'b0;
		// released data lines never hold a stale word
		mem_rdata <= ~mem_rdata;
		if (rst) begin
			bus_grant_pin <= 1'b0;
			gcnt <= 0;
			wcnt <= 0;
			mem_rdata <= 16'h0000;
		end else begin
			gcnt <= bus_req_r ? gcnt + 1 : 0;
			bus_grant_pin <= bus_req_r && (gcnt >= 8);
			if (!rd_req_r || rd_ack) begin
				wcnt <= 0;
			end else if (wcnt >= (slow ? 4 : 1)) begin
				rd_ack <= 1'b1;
				mem_rdata <= mem[mem_addr_r[11:1]];
				wcnt <= 0;
			end else begin
				wcnt <= wcnt + 1;
			end
		end
	end
endmodule : tda_mem_model

// file: test/tda_engine_tb_top.sv
// self-checking bench of the display list and attribute engine
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("[FAIL] %0t got %h want %h", $time, g, e); \
	end end
module tda_engine_tb_top;
	logic ref_clk, rst, clk_en, ctrl_enable, seg_mode, demand_mode, slow;
	logic flag_is_msb, script_bypass, scroll_enable, frame_start;
	logic char_tick, bus_grant_pin, bus_req_r, rd_req_r, rd_ack;
	logic disp_active_r, highlight_r, reverse_r, line_on_r, blank_r;
	logic scroll_row_done_r;
	logic [23:0] top_of_page_ptr, top_of_window_ptr, mem_addr_r;
	logic [7:0] flag_code, blink_period, blink_on_frames, scroll_rate;
	logic [7:0] char_code_r;
	logic [9:0] redef_mask;
	logic [4:0] script_shift, ul_pos, strike_ofs, row_lines, scan_line;
	logic [4:0] row_addr_r, scroll_off_r;
	logic [2:0] xy_style, attr_style;
	logic [13:0] attr_pins_r;
	logic [15:0] mem_rdata;
	int bad_count = 0;
	int total_checks = 0;
	int done_cnt = 0;
	logic [7:0] qc[$];
	logic [13:0] qa[$];
	logic [2:0] qf[$];
	logic [7:0] ec[7] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h47, 8'h57};
	logic [4:0] qr[$];
	logic [13:0] ea[6] = '{14'h0, 14'h7, 14'h80, 14'h10, 14'h10, 14'h10};
	logic [2:0] ef[6] = '{3'h1, 3'h6, 3'h2, 3'h1, 3'h1, 3'h1};
	logic [4:0] er[6] = '{5'h7, 5'h9, 5'h7, 5'h7, 5'h7, 5'h7};

	tda_engine #(.DEPTH(8)) dut_u (.ref_clk, .rst, .clk_en, .ctrl_enable,
		.top_of_page_ptr, .top_of_window_ptr, .seg_mode, .demand_mode,
		.flag_is_msb, .flag_code, .redef_mask, .script_bypass,
		.script_shift, .ul_pos, .strike_ofs, .blink_period,
		.blink_on_frames, .xy_style, .attr_style, .scroll_enable,
		.scroll_rate, .row_lines, .frame_start, .char_tick, .scan_line,
		.bus_grant_pin, .bus_req_r, .rd_req_r, .mem_addr_r, .rd_ack,
		.mem_rdata, .disp_active_r, .char_code_r, .row_addr_r,
		.attr_pins_r, .highlight_r, .reverse_r, .line_on_r, .blank_r,
		.scroll_row_done_r, .scroll_off_r);
	tda_mem_model mem_u (.ref_clk, .rst, .slow, .bus_req_r, .rd_req_r,
		.mem_addr_r, .bus_grant_pin, .rd_ack, .mem_rdata);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (scroll_row_done_r === 1'b1) done_cnt++;
	end

	task automatic ld(input int a, input logic [15:0] w[$]);
		foreach (w[i]) mem_u.mem[(a >> 1) + i] = w[i];
	endtask : ld
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task frame;
		@(posedge ref_clk) frame_start <= 1'b1;
		@(posedge ref_clk) frame_start <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask : frame

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, clk_en, demand_mode} = 3'h7;
		{ctrl_enable, seg_mode, flag_is_msb, script_bypass, slow} = 5'h0;
		{scroll_enable, frame_start, char_tick} = 3'h0;
		{top_of_page_ptr, top_of_window_ptr} = {24'h000100, 24'h000400};
		{flag_code, redef_mask, script_shift} = {8'hfe, 10'h0, 5'h2};
		{ul_pos, strike_ofs, row_lines, scan_line} = 20'h38a27;
		{blink_period, blink_on_frames, scroll_rate} = 24'h030201;
		{xy_style, attr_style} = {tda_pkg::STY_UL, tda_pkg::STY_REV};
		// lists chained top first, flag code marks each attribute word
		ld(32'h100, '{16'h0200, 16'h0000, 16'h0000});
		ld(32'h200, '{16'h0, 16'h0, 16'h0300, 16'h0, 16'h000b});
		ld(32'h300, '{16'h41, 16'hfe, 16'h7, 16'h42, 16'hfe, 16'h80,
			16'h43, 16'hfe, 16'h8010, 16'h44, 16'h45, 16'hfe, 16'h4000,
			16'h46, 16'h47});
		ld(32'h400, '{16'h0, 16'h0, 16'h0500, 16'h0});
		ld(32'h500, '{16'h0, 16'h0, 16'h0600, 16'h0, 16'h0001});
		ld(32'h600, '{16'h0057});
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk) ctrl_enable <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(bus_req_r, 1'b1)
		`CHK(disp_active_r, 1'b0)
		// fifo fills with no ticks until display starts
		for (int i = 0; i < 3000 && disp_active_r !== 1'b1; i++)
			@(posedge ref_clk);
		if (disp_active_r !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %0t display never started", $time);
			report_and_stop();
		end
		for (int i = 0; i < 60; i++) begin
			@(posedge ref_clk) char_tick <= 1'b1;
			@(posedge ref_clk) char_tick <= 1'b0;
			repeat (4) @(posedge ref_clk);
			@(negedge ref_clk);
			if (blank_r === 1'b0) begin
				qc.push_back(char_code_r);
				qa.push_back(attr_pins_r);
				qf.push_back({highlight_r, reverse_r, line_on_r});
				qr.push_back(row_addr_r);
			end
		end
		`CHK(qc.size(), 7)
		foreach (ec[i]) `CHK(qc[i], ec[i])
		foreach (ea[i]) `CHK(qa[i], ea[i])
		foreach (ef[i]) `CHK(qf[i], ef[i])
		foreach (er[i]) `CHK(qr[i], er[i])
		$display("test display list done");
		// scroll steps once every two frames with rate one, two-line rows
		@(posedge ref_clk) slow <= 1'b1;
		seg_mode <= 1'b1;
		row_lines <= 5'h02;
		scroll_enable <= 1'b1;
		repeat (2) frame();
		`CHK(scroll_off_r, 5'h1)
		`CHK(done_cnt, 0)
		repeat (2) frame();
		`CHK(scroll_off_r, 5'h0)
		`CHK(done_cnt, 1)
		$display("test scroll done");
		report_and_stop();
	end
endmodule : tda_engine_tb_top
